// ===== tseb_top.sv
`timescale 1ns/100ps
module tseb_top #(
  parameter int NCH = tseb_pkg::NCH_DEF
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic slice_long_i,
  input wire logic sb_slice_i,
  output logic ret_slice_o,
  input wire logic config_start_n_i,
  output logic config_complete_o,
  input wire logic ctrl_clk_i,
  input wire logic ctrl_cs_n_i,
  input wire logic control_serial_in_i,
  output logic ctrl_do_o,
  input wire logic [NCH-1:0] trig_i,
  input wire logic [NCH-1:0] disc_i,
  input wire logic adc_vld_i,
  input wire logic [NCH*tseb_pkg::SAMPLE_W-1:0] sample_i,
  output tseb_pkg::tseb_lane_t [tseb_pkg::SETS-1:0] lane_o,
  output tseb_pkg::tseb_sram_t sram_o,
  input wire logic [tseb_pkg::SRAM_DW-1:0] sram_dq_i,
  input wire logic [tseb_pkg::SPARE_N-1:0] spare_i,
  input wire logic [tseb_pkg::SPARE_N-1:0] spare_dir_i,
  output logic [tseb_pkg::SPARE_N-1:0] spare_o,
  output logic [tseb_pkg::SPARE_N-1:0] spare_oe_o
);
  import tseb_pkg::*;

  if (NCH % SETS != 0 || NCH < SETS || NCH > (1 << CH_W)) begin : g_chk
    $error("NCH must be a multiple of 4 between 4 and 16");
  end

  function automatic logic [WORD_LONG-1:0] build_word(
    input logic [CH_W-1:0] ch,
    input logic [TS_W-1:0] ts,
    input logic [SAMPLE_W-1:0] smp,
    input logic [SEQ_W-1:0] seq,
    input logic [SPARE_N-1:0] sp,
    input logic lng
  );
    logic [WORD_LONG-1:0] w;
    w = {sp, seq, ch, ts, smp, seq[7:0], 4'h0};
    if (!lng) begin
      w[WORD_LONG-1:WORD_SHORT] = '0;
    end
    return w;
  endfunction

  // ****************************************
  // Slice counter and returned marker
  // ****************************************
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] slen_last;
  logic slice_end;
  logic ret_slice_r;
  logic [SEQ_W-1:0] seq_r;

  assign slen_last = slice_long_i ? CNT_W'(SLICE_LONG - 1) :
                                    CNT_W'(SLICE_SHORT - 1);
  assign slice_end = (cnt_r >= slen_last) && !sb_slice_i;

  always_comb begin
    if (sb_slice_i) begin
      cnt_nxt = CNT_W'(1);
    end else if (cnt_r >= slen_last) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= CNT_RST;
      ret_slice_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      ret_slice_r <= (cnt_nxt == '0);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_r <= SEQ_RST;
    end else if (slice_end) begin
      seq_r <= seq_r + 1'b1;
    end
  end

  assign ret_slice_o = ret_slice_r;

  // ****************************************
  // Channel front end
  // ****************************************
  logic [NCH-1:0] disc_q;
  logic [NCH-1:0] trig_q;
  logic [NCH-1:0] armed_r;
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] take;
  logic [TS_W-1:0] ts_r [NCH];
  logic [TS_W-1:0] tsq_r [NCH];
  logic [SAMPLE_W-1:0] hold_r [NCH];
  logic [SAMPLE_W-1:0] samp_r [NCH];

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      disc_q <= '1;
      trig_q <= '0;
    end else begin
      disc_q <= disc_i;
      trig_q <= trig_i;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        ts_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!disc_i[c] && disc_q[c] && !armed_r[c]) begin
          ts_r[c] <= cnt_r[TS_W-1:0];
          armed_r[c] <= (cnt_nxt != '0);
        end else if (cnt_nxt == '0) begin
          armed_r[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        hold_r[c] <= '0;
      end
    end else if (adc_vld_i) begin
      for (int c = 0; c < NCH; c++) begin
        hold_r[c] <= sample_i[c*SAMPLE_W +: SAMPLE_W];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        samp_r[c] <= '0;
        tsq_r[c] <= '0;
      end
    end else begin
      pend_r <= (pend_r & ~take) | (trig_i & ~trig_q);
      for (int c = 0; c < NCH; c++) begin
        if (trig_i[c] && !trig_q[c]) begin
          samp_r[c] <= hold_r[c];
          tsq_r[c] <= ts_r[c];
        end
      end
    end
  end

  // ****************************************
  // Slice-end selection stage
  // ****************************************
  logic [SETS-1:0] found;
  logic [CH_W-1:0] sel [SETS];
  logic [SETS-1:0] wvld_r;
  logic [WORD_LONG-1:0] wd_r [SETS];
  logic [SPARE_N-1:0] spare_r;

  always_comb begin
    take = '0;
    found = '0;
    for (int s = 0; s < SETS; s++) begin
      sel[s] = '0;
      for (int k = 0; k < NCH / SETS; k++) begin
        if (slice_end && pend_r[k*SETS+s] && !found[s]) begin
          found[s] = 1'b1;
          sel[s] = CH_W'(k*SETS+s);
          take[k*SETS+s] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wvld_r <= '0;
      spare_r <= '0;
      for (int s = 0; s < SETS; s++) begin
        wd_r[s] <= '0;
      end
    end else begin
      spare_r <= spare_i;
      if (slice_end) begin
        wvld_r <= found;
        for (int s = 0; s < SETS; s++) begin
          wd_r[s] <= build_word(sel[s], tsq_r[sel[s]], samp_r[sel[s]],
                                seq_r, spare_r, slice_long_i);
        end
      end
    end
  end

  for (genvar s = 0; s < SETS; s++) begin : g_set
    tseb_lane_ser u_ser (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(ret_slice_r),
      .word_vld_i(wvld_r[s]),
      .long_i(slice_long_i),
      .word_i(wd_r[s]),
      .lane_o(lane_o[s])
    );
  end

  // ****************************************
  // Control serial channel and memory
  // ****************************************
  logic ctrl_clk_q;
  logic cs_q;
  logic [SPI_W-1:0] sh_in_r;
  logic [SPI_W-1:0] sh_out_r;
  logic [SPI_CNT_W-1:0] bit_r;
  logic ctrl_do_r;
  logic spi_done;
  logic rd_pend_r;
  logic [SRAM_DW-1:0] rd_data_r;
  tseb_sram_t sram_r;

  assign spi_done = ctrl_cs_n_i && !cs_q && (bit_r == SPI_CNT_W'(SPI_W));

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_clk_q <= 1'b0;
      cs_q <= 1'b1;
      sh_in_r <= '0;
      sh_out_r <= '0;
      bit_r <= '0;
      ctrl_do_r <= 1'b0;
    end else begin
      ctrl_clk_q <= ctrl_clk_i;
      cs_q <= ctrl_cs_n_i;
      if (ctrl_cs_n_i) begin
        bit_r <= '0;
        sh_out_r <= {rd_data_r, seq_r};
      end else if (ctrl_clk_i && !ctrl_clk_q) begin
        sh_in_r <= {sh_in_r[SPI_W-2:0], control_serial_in_i};
        if (bit_r != SPI_CNT_W'(SPI_W)) begin
          bit_r <= bit_r + 1'b1;
        end
      end else if (!ctrl_clk_i && ctrl_clk_q) begin
        ctrl_do_r <= sh_out_r[SPI_W-1];
        sh_out_r <= {sh_out_r[SPI_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sram_r <= '{addr: '0, wdata: '0, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0};
      rd_pend_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      sram_r.we_n <= 1'b1;
      sram_r.oe_n <= 1'b1;
      sram_r.dq_oe <= 1'b0;
      rd_pend_r <= 1'b0;
      if (rd_pend_r) begin
        rd_data_r <= sram_dq_i;
      end
      if (spi_done) begin
        sram_r.addr <= sh_in_r[SPI_AD_LSB +: SRAM_AW];
        sram_r.wdata <= sh_in_r[SRAM_DW-1:0];
        if (sh_in_r[SPI_WR_BIT]) begin
          sram_r.we_n <= 1'b0;
          sram_r.dq_oe <= 1'b1;
        end else begin
          sram_r.oe_n <= 1'b0;
          rd_pend_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Programming status and spare lines
  // ****************************************
  logic cfg_done_r;
  logic [SPARE_N-1:0] spare_o_r;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_done_r <= 1'b0;
      spare_o_r <= '0;
    end else begin
      cfg_done_r <= config_start_n_i;
      spare_o_r <= seq_r[SPARE_N-1:0];
    end
  end

  assign config_complete_o = cfg_done_r;
  assign ctrl_do_o = ctrl_do_r;
  assign sram_o = sram_r;
  assign spare_o = spare_o_r;
  assign spare_oe_o = spare_dir_i;

  // ****************************************
  // Checks
  // ****************************************
  slice_wrap_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cnt_r == slen_last && !sb_slice_i && $stable(slice_long_i))
      |=> ret_slice_o ##1 !ret_slice_o)
    else $error("slice marker not on wrap");
  marker_cnt_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ret_slice_o == (cnt_r == '0))
    else $error("returned marker off slice start");
  resync_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sb_slice_i |=> cnt_r == CNT_W'(1))
    else $error("counter not aligned to support marker");
  word_start_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(lane_o[0].vld) |-> cnt_r == CNT_W'(1))
    else $error("word started off slice cycle one");
  stage_take_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (slice_end && pend_r[0]) |=> wvld_r[0] && ret_slice_o)
    else $error("pending channel not staged at slice end");
  fall_stamp_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (!disc_i[0] && disc_q[0] && !armed_r[0]) |=> ts_r[0] == $past(cnt_r[3:0]))
    else $error("arrival stamp not taken on falling edge");
  trig_pend_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (trig_i[0] && !trig_q[0]) |=> pend_r[0])
    else $error("trigger did not start processing");
  sram_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (spi_done && sh_in_r[SPI_WR_BIT]) |=> !sram_o.we_n && sram_o.dq_oe ##1 sram_o.we_n)
    else $error("memory write strobe wrong");
  one_word_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $onehot0(take[NCH-1:0] & {(NCH/SETS){4'h1}}))
    else $error("two words chosen for one lane set");
  cover_short_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    !slice_long_i && $rose(lane_o[0].vld));
  cover_long_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    slice_long_i && $rose(lane_o[3].vld));
  cover_wr_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sram_o.we_n);
  cover_rd_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_pend_r);

endmodule

// ===== tseb_pkg.sv
// Summary of operation
// - Data arriving from the support board is timed by the support board's forwarded clock and slice marker.
// - This board makes its own returned slice marker and launches all outgoing event words against it.
// - A slice lasts 8 or 16 clock cycles, chosen by a mode input.
// - Control traffic uses four single-ended serial lines: clock, data in, data out and chip select.
// - An event word is 32 bits in 8-cycle slices and 64 bits in 16-cycle slices.
// - Sixteen event lanes form four sets of four, and each set carries at most one word per slice.
// - Event processing is split into stages that each finish within one slice.
// - Eight spare lines run between the boards with user-chosen meaning and direction; the code drives their outputs with the low byte of seq_r.
// - Each channel records the arrival time of its timing pulse relative to the slice boundary.
// - The arrival time is taken on the falling edge of the channel's discriminator output.
// - Event processing for a channel starts when its energy trigger asserts.
// - Each channel delivers 12-bit samples at 10 to 65 megasamples per second.
// - This board owns its two-megabyte calibration memory, including loading it.
package tseb_pkg;

  // ****************************************
  // Slice and word geometry
  // ****************************************
  localparam int SLICE_SHORT = 8;
  localparam int SLICE_LONG = 16;
  localparam int CNT_W = 5;
  localparam int WORD_SHORT = 32;
  localparam int WORD_LONG = 64;
  localparam int LANES = 4;
  localparam int SETS = 4;
  localparam int NCH_DEF = 16;
  localparam int CH_W = 4;
  localparam int TS_W = 4;
  localparam int SAMPLE_W = 12;
  localparam int SEQ_W = 24;
  localparam int SPARE_N = 8;

  // ****************************************
  // Control channel and memory
  // ****************************************
  localparam int SRAM_AW = 20;
  localparam int SRAM_DW = 16;
  localparam int SPI_W = 40;
  localparam int SPI_CNT_W = 6;
  localparam int SPI_WR_BIT = 39;
  localparam int SPI_AD_LSB = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [SEQ_W-1:0] SEQ_RST = 24'h000000;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic vld;
    logic [LANES-1:0] d;
  } tseb_lane_t;

  typedef struct packed {
    logic [SRAM_AW-1:0] addr;
    logic [SRAM_DW-1:0] wdata;
    logic we_n;
    logic oe_n;
    logic dq_oe;
  } tseb_sram_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_SEND = 2'b01
  } tseb_ls_t;

endpackage

// ===== tseb_lane_ser.sv
`timescale 1ns/100ps
module tseb_lane_ser (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic word_vld_i,
  input wire logic long_i,
  input wire logic [tseb_pkg::WORD_LONG-1:0] word_i,
  output tseb_pkg::tseb_lane_t lane_o
);
  import tseb_pkg::*;

  tseb_ls_t state_r;
  logic [WORD_LONG-1:0] sh_r;
  logic [CNT_W-1:0] rem_r;
  tseb_lane_t lane_r;

  assign lane_o = lane_r;

  // ****************************************
  // Nibble serializer
  // ****************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= LS_IDLE;
      sh_r <= '0;
      rem_r <= CNT_RST;
      lane_r <= '0;
    end else if (load_i && word_vld_i) begin
      state_r <= LS_SEND;
      lane_r.vld <= 1'b1;
      lane_r.d <= word_i[LANES-1:0];
      sh_r <= {4'h0, word_i[WORD_LONG-1:LANES]};
      rem_r <= long_i ? CNT_W'(SLICE_LONG - 1) :
                        CNT_W'(SLICE_SHORT - 1);
    end else begin
      case (state_r)
        LS_SEND: begin
          if (rem_r != '0) begin
            lane_r.d <= sh_r[LANES-1:0];
            sh_r <= {4'h0, sh_r[WORD_LONG-1:LANES]};
            rem_r <= rem_r - 1'b1;
          end else begin
            state_r <= LS_IDLE;
            lane_r <= '0;
          end
        end
        default: begin
          state_r <= LS_IDLE;
          lane_r <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  short_word_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (load_i && word_vld_i && !long_i) |=> lane_o.vld [*8])
    else $error("short word not sent over 8 cycles");
  long_word_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (load_i && word_vld_i && long_i) |=> lane_o.vld [*8] ##1 lane_o.vld [*8])
    else $error("long word not sent over 16 cycles");
  first_nibble_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (load_i && word_vld_i) |=> lane_o.d == $past(word_i[3:0]))
    else $error("first nibble not launched after load");
  cover_long_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    load_i && word_vld_i && long_i);

endmodule

// ===== tseb_sb_model.sv
`timescale 1ns/100ps
module tseb_sb_model (
  input wire logic mclk_i,
  input wire logic long_i,
  input wire logic en_i,
  input wire logic ret_slice_i,
  input wire tseb_pkg::tseb_lane_t [tseb_pkg::SETS-1:0] lane_i,
  input wire logic ctrl_do_i,
  output logic sb_slice_o,
  output logic ctrl_clk_o,
  output logic ctrl_cs_n_o,
  output logic control_serial_in_o,
  output logic [tseb_pkg::SPI_W-1:0] ctrl_rx_o,
  output logic [tseb_pkg::SETS-1:0][tseb_pkg::WORD_LONG-1:0] rx_word_o,
  output logic [tseb_pkg::SETS-1:0][7:0] rx_n_o
);
  import tseb_pkg::*;
  int cnt;
  int idx [SETS];
  logic prev_ret;

  initial begin
    sb_slice_o = 1'b0;
    ctrl_clk_o = 1'b0;
    ctrl_cs_n_o = 1'b1;
    control_serial_in_o = 1'b0;
    ctrl_rx_o = '0;
    rx_word_o = '0;
    rx_n_o = '0;
    prev_ret = 1'b0;
    cnt = 0;
    idx = '{default: 0};
  end

  // ****************************************
  // Slice marker and event receiver
  // ****************************************
  always @(negedge mclk_i) begin
    if (!en_i) begin
      cnt <= 0;
      sb_slice_o <= 1'b0;
    end else begin
      sb_slice_o <= (cnt == 0);
      cnt <= (cnt + 1) % (long_i ? SLICE_LONG : SLICE_SHORT);
    end
  end

  // Words are framed from the cycle after the returned marker
  always @(posedge mclk_i) begin
    prev_ret <= ret_slice_i;
    for (int s = 0; s < SETS; s++) begin
      if (lane_i[s].vld && prev_ret) begin
        rx_word_o[s] <= {60'h0, lane_i[s].d};
        idx[s] <= 1;
      end else if (lane_i[s].vld) begin
        rx_word_o[s][idx[s]*LANES +: LANES] <= lane_i[s].d;
        idx[s] <= idx[s] + 1;
        if (idx[s] == (long_i ? WORD_LONG : WORD_SHORT) / LANES - 1) begin
          rx_n_o[s] <= rx_n_o[s] + 8'h01;
        end
      end
    end
  end

  // Control frame, MSB first, reply bit taken once its falling clock is seen
  task automatic send_frame(input logic [SPI_W-1:0] f);
    @(negedge mclk_i);
    ctrl_cs_n_o = 1'b0;
    for (int i = SPI_W - 1; i >= 0; i--) begin
      control_serial_in_o = f[i];
      repeat (3) @(negedge mclk_i);
      ctrl_clk_o = 1'b1;
      repeat (3) @(negedge mclk_i);
      ctrl_clk_o = 1'b0;
      @(negedge mclk_i);
      ctrl_rx_o[i] = ctrl_do_i;
    end
    repeat (2) @(negedge mclk_i);
    ctrl_cs_n_o = 1'b1;
    control_serial_in_o = ~control_serial_in_o;
  endtask
endmodule

// ===== tseb_top_tb.sv
`timescale 1ns/100ps
module tseb_top_tb;
  import tseb_pkg::*;
  logic mclk;
  logic rst;
  logic slice_long;
  logic sb_en;
  logic sb_slice;
  logic ret_slice;
  logic cfg_n;
  logic cfg_done;
  logic cclk;
  logic ccs_n;
  logic cdi;
  logic cdo;
  logic [15:0] trig;
  logic [15:0] disc;
  logic adc_vld;
  logic [16*SAMPLE_W-1:0] sample;
  tseb_lane_t [SETS-1:0] lane;
  tseb_sram_t sram;
  logic [SRAM_DW-1:0] dq;
  logic dq_hold;
  logic [SPARE_N-1:0] spare_in;
  logic [SPARE_N-1:0] spare_dir;
  logic [SPARE_N-1:0] spare_out;
  logic [SPARE_N-1:0] spare_oe;
  logic [SPI_W-1:0] ctrl_rx;
  logic [SETS-1:0][WORD_LONG-1:0] rx_word;
  logic [SETS-1:0][7:0] rx_n;
  int bad_count;
  int n_compared;

  tseb_top #(
    .NCH(16)
  ) dut (
    .mclk_i(mclk),
    .sys_rst_i(rst),
    .slice_long_i(slice_long),
    .sb_slice_i(sb_slice),
    .ret_slice_o(ret_slice),
    .config_start_n_i(cfg_n),
    .config_complete_o(cfg_done),
    .ctrl_clk_i(cclk),
    .ctrl_cs_n_i(ccs_n),
    .control_serial_in_i(cdi),
    .ctrl_do_o(cdo),
    .trig_i(trig),
    .disc_i(disc),
    .adc_vld_i(adc_vld),
    .sample_i(sample),
    .lane_o(lane),
    .sram_o(sram),
    .sram_dq_i(dq),
    .spare_i(spare_in),
    .spare_dir_i(spare_dir),
    .spare_o(spare_out),
    .spare_oe_o(spare_oe)
  );

  tseb_sb_model sb (
    .mclk_i(mclk),
    .long_i(slice_long),
    .en_i(sb_en),
    .ret_slice_i(ret_slice),
    .lane_i(lane),
    .ctrl_do_i(cdo),
    .sb_slice_o(sb_slice),
    .ctrl_clk_o(cclk),
    .ctrl_cs_n_o(ccs_n),
    .control_serial_in_o(cdi),
    .ctrl_rx_o(ctrl_rx),
    .rx_word_o(rx_word),
    .rx_n_o(rx_n)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Memory returns data while read, holds one cycle, then inverts every cycle
  always @(negedge mclk) begin
    if (!sram.oe_n) begin
      dq <= sram.addr[15:0] ^ 16'ha5c3;
      dq_hold <= 1'b1;
    end else if (dq_hold) begin
      dq_hold <= 1'b0;
    end else begin
      dq <= ~dq;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_ret();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ret_slice !== 1'b1 && n < 40);
    if (ret_slice !== 1'b1) begin
      chk("slice marker wait", 1, 0);
      conclude();
    end
  endtask

  task automatic wait_rx(input int s, input logic [7:0] tgt);
    int n;
    n = 0;
    while (rx_n[s] !== tgt && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (rx_n[s] !== tgt) begin
      chk("word count", tgt, rx_n[s]);
      conclude();
    end
  endtask

  task automatic wait_strobe(input logic rd);
    int n;
    n = 0;
    while ((rd ? sram.oe_n : sram.we_n) !== 1'b0 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if ((rd ? sram.oe_n : sram.we_n) !== 1'b0) begin
      chk("memory strobe wait", 0, 1);
      conclude();
    end
  endtask

  task automatic do_reset(input logic lng);
    @(negedge mclk);
    sb_en <= 1'b0;
    slice_long <= lng;
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    chk("reset outputs", {1'b1, 4'h0, 2'b11, 1'b0, 8'h00, 1'b0},
        {ret_slice, lane[3].vld, lane[2].vld, lane[1].vld, lane[0].vld,
         sram.we_n, sram.oe_n, sram.dq_oe, spare_out, cfg_done});
    rst = 1'b0;
  endtask

  task automatic load_samples();
    for (int c = 0; c < 16; c++) begin
      sample[c*SAMPLE_W +: SAMPLE_W] = 12'h3c0 + 12'(c);
    end
    adc_vld = 1'b1;
    @(negedge mclk);
    adc_vld = 1'b0;
    sample = ~sample;
  endtask

  task automatic chk_word(input logic [63:0] w, input int c,
                          input logic lng);
    chk("word channel", 64'(c), w[31:28]);
    chk("word sample", 12'h3c0 + 12'(c), w[23:12]);
    chk("word low nibble", 0, w[3:0]);
    if (!lng) chk("short word top", 0, w[63:32]);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_period(input int exp);
    int n;
    wait_ret();
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ret_slice !== 1'b1 && n < 40);
    chk("slice length", 64'(exp), 64'(n));
  endtask

  task automatic sc_resync();
    int miss;
    int hits;
    logic prev;
    miss = 0;
    hits = 0;
    wait_ret();
    repeat (3) @(negedge mclk);
    sb_en <= 1'b1;
    repeat (12) @(negedge mclk);
    prev = ret_slice;
    repeat (32) begin
      @(negedge mclk);
      if (prev !== sb_slice) miss++;
      if (sb_slice === 1'b1) hits++;
      prev = ret_slice;
    end
    chk("marker misalignments", 0, 64'(miss));
    chk("support markers", 4, 64'(hits));
  endtask

  task automatic sc_short();
    logic [7:0] n0;
    logic [7:0] n1;
    logic [7:0] n23;
    logic [63:0] w0;
    logic [63:0] w1;
    n0 = rx_n[0];
    n1 = rx_n[1];
    n23 = rx_n[2] + rx_n[3];
    load_samples();
    wait_ret();
    @(negedge mclk);
    disc[0] = 1'b0;
    repeat (4) @(negedge mclk);
    disc[1] = 1'b0;
    @(negedge mclk);
    trig[0] = 1'b1;
    trig[1] = 1'b1;
    trig[4] = 1'b1;
    wait_rx(0, n0 + 8'h01);
    wait_rx(1, n1 + 8'h01);
    w0 = rx_word[0];
    w1 = rx_word[1];
    chk_word(w0, 0, 1'b0);
    chk_word(w1, 1, 1'b0);
    chk("stamp spacing", 4, w1[27:24] - w0[27:24]);
    chk("same slice tag", w0[11:4], w1[11:4]);
    wait_rx(0, n0 + 8'h02);
    chk_word(rx_word[0], 4, 1'b0);
    chk("next slice tag", w0[11:4] + 8'h01, rx_word[0][11:4]);
    chk("idle sets", n23, rx_n[2] + rx_n[3]);
    trig = '0;
    disc = '1;
  endtask

  task automatic sc_ctrl();
    sb.send_frame({1'b1, 3'h0, 20'h2b4c1, 16'hc3a5});
    wait_strobe(1'b0);
    chk("write strobe", {3'b011, 20'h2b4c1, 16'hc3a5},
        {sram.we_n, sram.oe_n, sram.dq_oe, sram.addr, sram.wdata});
    @(negedge mclk);
    chk("write strobe end", 1, sram.we_n);
    sb.send_frame({1'b0, 3'h0, 20'h01234, 16'h0000});
    wait_strobe(1'b1);
    chk("read strobe", {3'b100, 20'h01234},
        {sram.we_n, sram.oe_n, sram.dq_oe, sram.addr});
    repeat (4) @(negedge mclk);
    sb.send_frame(40'h0);
    chk("read return", 16'h1234 ^ 16'ha5c3, ctrl_rx[39:24]);
  endtask

  task automatic sc_misc();
    logic [7:0] a;
    cfg_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk("programming status low", 0, cfg_done);
    cfg_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk("programming status high", 1, cfg_done);
    spare_dir = 8'h5a;
    #1;
    chk("spare enables", 8'h5a, spare_oe);
    wait_ret();
    repeat (4) @(negedge mclk);
    a = spare_out;
    wait_ret();
    repeat (4) @(negedge mclk);
    chk("spare count", a + 8'h01, spare_out);
  endtask

  task automatic sc_long();
    logic [7:0] n3;
    do_reset(1'b1);
    sc_period(16);
    sb_en <= 1'b1;
    n3 = rx_n[3];
    spare_in = 8'h96;
    load_samples();
    trig[3] = 1'b1;
    wait_rx(3, n3 + 8'h01);
    chk_word(rx_word[3], 3, 1'b1);
    chk("spare byte", 8'h96, rx_word[3][63:56]);
    chk("sequence copy", rx_word[3][11:4], rx_word[3][39:32]);
    trig = '0;
  endtask

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst = 1'b1;
    slice_long = 1'b0;
    sb_en = 1'b0;
    cfg_n = 1'b1;
    trig = '0;
    disc = '1;
    adc_vld = 1'b0;
    sample = '0;
    dq = '0;
    dq_hold = 1'b0;
    spare_in = '0;
    spare_dir = '0;
    do_reset(1'b0);
    sc_period(8);
    sc_resync();
    sc_short();
    sc_ctrl();
    sc_misc();
    sc_long();
    conclude();
  end
endmodule
